// File: hdl/tsa_access_unit.sv
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tsa_access_unit
  import tsa_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // ahb-lite
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // frame bus pins
  input  wire logic              bitClock,
  input  wire logic              frameSync,
  input  wire logic              upstreamIn,
  output logic                   upstreamOut,
  output logic                   upstreamOe,
  input  wire logic              downstreamIn,
  output logic                   downstreamOut,
  output logic                   downstreamOe,
  // monitor steering from the other bus functions
  input  wire logic [NUM_CH-1:0] monitorReverse,
  // interrupt
  output logic                   irq
);

  // ****************************************************************
  // bus front end
  // ****************************************************************
  tsa_bus_t   bus;
  logic [7:0] rdData;

  tsa_ahb_slave u_slave (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .bus       (bus),
    .rdData    (rdData)
  );

  // ****************************************************************
  // pin synchronisation and bit-clock edges
  // ****************************************************************
  logic [3:0] pinSync;
  logic       bitClkS;
  logic       frameS;
  logic       upS;
  logic       downS;
  logic       bitClkDly;
  logic       rise;
  logic       fall;

  tsa_sync #(.W(4)) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     ({bitClock, frameSync, upstreamIn, downstreamIn}),
    .dout    (pinSync)
  );

  assign {bitClkS, frameS, upS, downS} = pinSync;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bitClkDly <= 1'b0;
    end else begin
      bitClkDly <= bitClkS;
    end
  end

  // timing is kept in whole bit-clock periods; the double-rate clock is
  // not needed because one bit period always spans two of its periods
  // bit-clock time base
  assign rise = bitClkS & ~bitClkDly;
  assign fall = ~bitClkS & bitClkDly;

  // ****************************************************************
  // frame position: slot in [7:3], bit in [2:0]
  // ****************************************************************
  logic [7:0] pos;
  logic [7:0] nextPos;

  assign nextPos = frameS ? 8'h00 : pos + 8'h01;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pos <= 8'h00;
    end else if (rise) begin
      pos <= nextPos;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] slotPort [NUM_CH];
  logic [7:0] pairCtrl [2];
  logic [7:0] dataReg  [NUM_CH];
  logic [7:0] status;
  logic [7:0] mask;
  logic       statusRead;
  logic       ackWrite;

  assign statusRead = bus.rd & (bus.addr == OFF_SYNC_TRANSFER_STAT);
  assign ackWrite   = bus.wr & (bus.addr == OFF_SYNC_TRANSFER_ACK);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pairCtrl[0] <= RST_PAIR_CTRL;
      pairCtrl[1] <= RST_PAIR_CTRL;
      mask        <= RST_MASK;
    end else if (bus.wr) begin
      if (bus.addr == OFF_PAIR_CONTROL_A) begin
        pairCtrl[0] <= bus.wdata;
      end
      if (bus.addr == OFF_PAIR_CONTROL_B) begin
        pairCtrl[1] <= bus.wdata;
      end
      if (bus.addr == OFF_SYNC_TRANSFER_MASK) begin
        mask <= bus.wdata;
      end
    end
  end

  // ****************************************************************
  // per-register datapath
  // ****************************************************************
  tsa_slot_t        cfg       [NUM_CH];
  logic [NUM_CH-1:0] capDone;
  logic [7:0]        capByte  [NUM_CH];
  logic [NUM_CH-1:0] upDrv;
  logic [NUM_CH-1:0] downDrv;
  logic [NUM_CH-1:0] drvBit;
  logic [NUM_CH-1:0] fire;
  logic [NUM_CH-1:0] check;
  logic [NUM_CH-1:0] ovf;
  logic [NUM_CH-1:0] related [NUM_CH];
  logic [NUM_CH-1:0] pending;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      localparam int P = c ^ 1;
      localparam int H = c / 2;

      logic       swap;
      logic       inEn;
      logic       outEn;
      tsa_slot_t  inCfg;
      logic       inBit;
      logic       inHit;
      logic       drvHit;
      logic [7:0] evtPos;
      logic [7:0] chkPos;
      logic [7:0] capShift;

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          slotPort[c] <= RST_SLOT_PORT;
        end else if (bus.wr && bus.addr == OFF_SPS[c]) begin
          slotPort[c] <= bus.wdata;
        end
      end

      assign cfg[c].slot    = slotPort[c][SPS_SLOT_LSB +: 5];
      assign cfg[c].lineSel = slotPort[c][SPS_LINE_BIT];

      assign swap  = pairCtrl[H][PC_SWAP_BIT];
      assign inEn  = pairCtrl[H][PC_IN_EN_LSB + (c % 2)];
      assign outEn = pairCtrl[H][PC_OUT_EN_LSB + (c % 2)];

      assign inCfg = swap ? cfg[P] : cfg[c];
      assign inBit = inCfg.lineSel ? upS : downS;
      assign inHit = (pos[7:3] == inCfg.slot);

      // sample mid-bit, away from the edge where the far end changes data
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          capShift <= 8'h00;
        end else if (fall && inHit && inEn) begin
          capShift <= {capShift[6:0], inBit};
        end
      end

      assign capDone[c] = fall & inHit & inEn & (pos[2:0] == LAST_BIT);
      assign capByte[c] = {capShift[6:0], inBit};

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          dataReg[c] <= RST_DATA;
        end else if (bus.wr && bus.addr == OFF_DATA[c]) begin
          dataReg[c] <= bus.wdata;
        end else if (capDone[c] && !monitorReverse[c]) begin
          dataReg[c] <= capByte[c];
        end else if (capDone[P] && monitorReverse[P]) begin
          dataReg[c] <= capByte[P];
        end
      end

      assign drvHit     = outEn & (nextPos[7:3] == cfg[c].slot);
      assign drvBit[c]  = dataReg[c][LAST_BIT - nextPos[2:0]];
      assign upDrv[c]   = drvHit & ~cfg[c].lineSel;
      assign downDrv[c] = drvHit & cfg[c].lineSel;

      assign evtPos   = {cfg[c].slot, LAST_BIT} +
                        (cfg[c].lineSel ? EVT_DELAY_LINE1 : EVT_DELAY_LINE0);
      assign fire[c]  = rise & (nextPos == evtPos);
      assign chkPos   = {cfg[c].slot, 3'h0} -
                        (cfg[c].lineSel ? ACK_LEAD_LINE1 : ACK_LEAD_LINE0);
      assign check[c] = rise & (nextPos == chkPos);

      // own event, or all enabled ones when own is masked
      // a masked overflow never widens its reach to other events
      assign related[c] = (mask[ST_EVT_LSB + c] && !mask[ST_OVF_LSB + c]) ?
                          ~mask[ST_EVT_LSB +: NUM_CH] : NUM_CH'(1 << c);
      assign ovf[c]     = check[c] & (|(pending & related[c]));
    end
  endgenerate

  // ****************************************************************
  // line drivers, changed on the bit-clock rising edge
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upstreamOut   <= 1'b0;
      upstreamOe    <= 1'b0;
      downstreamOut <= 1'b0;
      downstreamOe  <= 1'b0;
    end else if (rise) begin
      upstreamOut   <= |(upDrv & drvBit);
      upstreamOe    <= |upDrv;
      downstreamOut <= |(downDrv & drvBit);
      downstreamOe  <= |downDrv;
    end
  end

  // ****************************************************************
  // synchronous transfer events and overflows
  // ****************************************************************
  logic [NUM_CH-1:0] ovfClr;

  always_comb begin
    ovfClr = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ovf[i]) begin
        ovfClr = ovfClr | related[i];
      end
    end
  end

  // a fresh event outlives an ack or overflow in the same cycle
  // ack clears outstanding events
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~ovfClr & ~(ackWrite ? bus.wdata[NUM_CH-1:0] : '0)) | fire;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status <= RST_STATUS;
    end else begin
      status <= (statusRead ? 8'h00 : status) | {ovf, fire};
    end
  end

  assign irq = |(status & ~mask);

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    rdData = 8'h00;
    unique case (bus.addr)
      OFF_SLOT_ACCESS_DATA_A0: rdData = dataReg[0];
      OFF_SLOT_ACCESS_DATA_A1: rdData = dataReg[1];
      OFF_SLOT_ACCESS_DATA_B0: rdData = dataReg[2];
      OFF_SLOT_ACCESS_DATA_B1: rdData = dataReg[3];
      OFF_SLOT_PORT_SELECT_A0: rdData = slotPort[0];
      OFF_SLOT_PORT_SELECT_A1: rdData = slotPort[1];
      OFF_SLOT_PORT_SELECT_B0: rdData = slotPort[2];
      OFF_SLOT_PORT_SELECT_B1: rdData = slotPort[3];
      OFF_PAIR_CONTROL_A:      rdData = pairCtrl[0];
      OFF_PAIR_CONTROL_B:      rdData = pairCtrl[1];
      OFF_SYNC_TRANSFER_STAT:  rdData = status;
      OFF_SYNC_TRANSFER_MASK:  rdData = mask;
      default:                 rdData = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// File: inc/tsa_pkg.sv
// ****************************************************************
// time-slot access unit: shared constants and types
// ****************************************************************
package tsa_pkg;

  localparam int NUM_CH    = 4;
  localparam int SLOT_BITS = 8;

  // ****************************************************************
  // register offsets (byte addresses on the bus)
  // ****************************************************************
  localparam logic [7:0] OFF_SLOT_ACCESS_DATA_A0 = 8'h00;
  localparam logic [7:0] OFF_SLOT_ACCESS_DATA_A1 = 8'h04;
  localparam logic [7:0] OFF_SLOT_ACCESS_DATA_B0 = 8'h08;
  localparam logic [7:0] OFF_SLOT_ACCESS_DATA_B1 = 8'h0C;
  localparam logic [7:0] OFF_SLOT_PORT_SELECT_A0 = 8'h10;
  localparam logic [7:0] OFF_SLOT_PORT_SELECT_A1 = 8'h14;
  localparam logic [7:0] OFF_SLOT_PORT_SELECT_B0 = 8'h18;
  localparam logic [7:0] OFF_SLOT_PORT_SELECT_B1 = 8'h1C;
  localparam logic [7:0] OFF_PAIR_CONTROL_A      = 8'h20;
  localparam logic [7:0] OFF_PAIR_CONTROL_B      = 8'h24;
  localparam logic [7:0] OFF_SYNC_TRANSFER_STAT  = 8'h28;
  localparam logic [7:0] OFF_SYNC_TRANSFER_ACK   = 8'h2C;
  localparam logic [7:0] OFF_SYNC_TRANSFER_MASK  = 8'h30;

  localparam logic [7:0] OFF_DATA [NUM_CH] = '{OFF_SLOT_ACCESS_DATA_A0, OFF_SLOT_ACCESS_DATA_A1,
                                               OFF_SLOT_ACCESS_DATA_B0, OFF_SLOT_ACCESS_DATA_B1};
  localparam logic [7:0] OFF_SPS  [NUM_CH] = '{OFF_SLOT_PORT_SELECT_A0, OFF_SLOT_PORT_SELECT_A1,
                                               OFF_SLOT_PORT_SELECT_B0, OFF_SLOT_PORT_SELECT_B1};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SPS_SLOT_LSB  = 0;
  localparam int SPS_LINE_BIT  = 5;
  localparam int PC_IN_EN_LSB  = 0;
  localparam int PC_OUT_EN_LSB = 2;
  localparam int PC_SWAP_BIT   = 4;
  localparam int ST_EVT_LSB    = 0;
  localparam int ST_OVF_LSB    = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [7:0] RST_SLOT_PORT = 8'h00;
  localparam logic [7:0] RST_PAIR_CTRL = 8'h00;
  localparam logic [7:0] RST_STATUS    = 8'h00;
  localparam logic [7:0] RST_MASK      = 8'hFF;

  // ****************************************************************
  // timing in bit-clock periods
  // ****************************************************************
  localparam logic [7:0] EVT_DELAY_LINE0 = 8'h02;
  localparam logic [7:0] EVT_DELAY_LINE1 = 8'h01;
  localparam logic [7:0] ACK_LEAD_LINE0  = 8'h01;
  localparam logic [7:0] ACK_LEAD_LINE1  = 8'h00;
  localparam logic [2:0] LAST_BIT        = 3'h7;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsa_bus_t;

  typedef struct packed {
    logic       lineSel;
    logic [4:0] slot;
  } tsa_slot_t;

endpackage

// File: hdl/tsa_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-stage synchroniser for pin inputs
// ****************************************************************
module tsa_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule
`default_nettype wire

// File: hdl/tsa_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// ahb-lite slave front end
// ****************************************************************
module tsa_ahb_slave
  import tsa_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register side
  output tsa_bus_t         bus,
  input  wire logic [7:0]  rdData
);

  logic       take;
  logic       upperZero;
  logic       wrPend;
  logic       wrOk;
  logic [7:0] wrAddr;

  // only whole-word single transfers are expected; hsize is not checked
  assign take      = hsel & hready & htrans[1];
  assign upperZero = (haddr[31:8] == 24'h000000);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPend <= 1'b0;
      wrOk   <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= take & hwrite;
      if (take & hwrite) begin
        wrOk   <= upperZero;
        wrAddr <= haddr[7:0];
      end
    end
  end

  // one wait state on writes so a following read sees the new value
  assign hreadyout = ~wrPend;
  assign hresp     = 1'b0;

  always_comb begin
    bus.wr    = wrPend & wrOk;
    bus.rd    = take & ~hwrite & upperZero;
    bus.addr  = wrPend ? wrAddr : haddr[7:0];
    bus.wdata = hwdata[7:0];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      hrdata <= upperZero ? {24'h000000, rdData} : 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// File: bench/tsa_access_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// port checker for the access unit
// ********
module tsa_access_unit_asserts
  import tsa_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // ahb-lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // frame bus and interrupt
  input wire logic        bitClock,
  input wire logic        upstreamOut,
  input wire logic        upstreamOe,
  input wire logic        downstreamOut,
  input wire logic        downstreamOe,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic [6:0] upRun;
  logic [6:0] dnRun;
  logic [3:0] sinceRise;
  logic       bitClkQ;
  wire logic  take = hsel & hready & htrans[1];

  // run lengths saturate so two adjacent slots cannot wrap
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upRun <= 7'h00;
      dnRun <= 7'h00;
    end else begin
      upRun <= !upstreamOe ? 7'h00 : (upRun == 7'h7F ? upRun : upRun + 7'h01);
      dnRun <= !downstreamOe ? 7'h00 : (dnRun == 7'h7F ? dnRun : dnRun + 7'h01);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bitClkQ   <= 1'b0;
      sinceRise <= 4'hF;
    end else begin
      bitClkQ   <= bitClock;
      sinceRise <= (bitClock & !bitClkQ) ? 4'h0 : (sinceRise == 4'hF ? sinceRise : sinceRise + 4'h1);
    end
  end

  sequence wr_taken;
    take && hwrite;
  endsequence
  sequence wr_stall;
    !hreadyout ##1 hreadyout;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave answered with an error");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_read_no_wait: assert property (take && !hwrite |=> hreadyout)
    else $error("read was stalled");
  a_write_one_wait: assert property (wr_taken |=> wr_stall)
    else $error("write wait state wrong");
  a_ready_short_low: assert property (!hreadyout |=> hreadyout)
    else $error("ready low too long");
  a_up_slot_whole: assert property ($fell(upstreamOe) |-> upRun >= 7'd60)
    else $error("upstream drive shorter than a slot");
  a_dn_slot_whole: assert property ($fell(downstreamOe) |-> dnRun >= 7'd60)
    else $error("downstream drive shorter than a slot");
  a_up_bit_edge: assert property ($changed({upstreamOut, upstreamOe}) |-> sinceRise <= 4'd5)
    else $error("upstream changed away from bit clock rise");
  a_dn_bit_edge: assert property ($changed({downstreamOut, downstreamOe}) |-> sinceRise <= 4'd5)
    else $error("downstream changed away from bit clock rise");
  a_irq_read_clear: assert property (take && !hwrite && haddr == {24'h0, OFF_SYNC_TRANSFER_STAT}
    |=> ##[0:2] !irq)
    else $error("status read left interrupt pending");
endmodule

bind tsa_access_unit tsa_access_unit_asserts i_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .bitClock(bitClock), .upstreamOut(upstreamOut), .upstreamOe(upstreamOe),
  .downstreamOut(downstreamOut), .downstreamOe(downstreamOe), .irq(irq)
);
`default_nettype wire

// File: bench/tsa_frame_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// far side of the frame bus
// ********
module tsa_frame_partner (
  // frame timing
  output logic bitClock,
  output logic frameSync,
  // line levels offered by the far side
  output logic upLine,
  output logic dnLine
);
  logic [7:0] pos;
  wire logic [7:0] nxt = pos + 8'h01;
  // slot s carries 101s upstream, 010s downstream
  wire logic [7:0] upByte = {3'h5, nxt[7:3]};
  wire logic [7:0] dnByte = {3'h2, nxt[7:3]};

  initial begin
    bitClock  = 1'b0;
    frameSync = 1'b1;
    pos       = 8'hFF;
    upLine    = 1'b1;
    dnLine    = 1'b1;
  end

  // bit clock runs free, 320 ns
  always #160 bitClock = ~bitClock;

  always @(posedge bitClock) begin
    pos    <= nxt;
    upLine <= upByte[3'h7 - nxt[2:0]];
    dnLine <= dnByte[3'h7 - nxt[2:0]];
  end

  // sync is seen at the rise that starts slot 0
  always @(negedge bitClock) frameSync <= (pos == 8'hFF);
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import tsa_pkg::*;
();
  logic              clk_sys;
  logic              rst_b;
  logic              hsel;
  logic              hwrite;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [NUM_CH-1:0] monitorReverse;
  logic              hreadyout, hresp, irq, bitClock, frameSync, pUp, pDn;
  logic              upstreamOut, upstreamOe, downstreamOut, downstreamOe;
  logic [7:0]        got;
  int                mismatches;
  int                checksDone;
  wire logic         hready = hreadyout;
  wire logic         upLine = upstreamOe ? upstreamOut : pUp;
  wire logic         dnLine = downstreamOe ? downstreamOut : pDn;

  tsa_access_unit i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bitClock(bitClock),
    .frameSync(frameSync), .upstreamIn(upLine), .upstreamOut(upstreamOut),
    .upstreamOe(upstreamOe), .downstreamIn(dnLine), .downstreamOut(downstreamOut),
    .downstreamOe(downstreamOe), .monitorReverse(monitorReverse), .irq(irq)
  );
  tsa_frame_partner i_far (.bitClock(bitClock), .frameSync(frameSync), .upLine(pUp), .dnLine(pDn));

  always #20 clk_sys = ~clk_sys;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // sel 0: ready, 1: irq, 2: upstream drive, 3: downstream drive, 4: frame sync
  task automatic wait_for(input int sel, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while ((sel == 0 ? hready : sel == 1 ? irq : sel == 2 ? upstreamOe :
                sel == 3 ? downstreamOe : frameSync) !== 1'b1 && n < lim);
    // hand back right after the rising edge that follows the falling edge at which the level was seen
    @(posedge clk_sys);
    if (n >= lim) begin
      mismatches++;
      report_and_stop;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_for(0, 40);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_for(0, 40);
    got = hrdata[7:0];
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp, input string nm);
    bus(1'b0, a, 8'h00);
    check(nm, got & m, exp);
  endtask

  task automatic grab(input logic ln);
    wait_for(ln ? 3 : 2, 5000);
    repeat (8) begin
      @(negedge bitClock);
      got = {got[6:0], ln ? downstreamOut : upstreamOut};
    end
    @(posedge clk_sys);
  endtask

  task automatic frames(input int n);
    repeat (n * 2100) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0; rst_b = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2;
    haddr = 32'h0; hwdata = 32'h0; monitorReverse = 4'h0; mismatches = 0; checksDone = 0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(OFF_SYNC_TRANSFER_STAT, 8'hFF, RST_STATUS, "status reset");
    rd(OFF_SYNC_TRANSFER_MASK, 8'hFF, RST_MASK, "mask reset");
    rd(OFF_SYNC_TRANSFER_ACK, 8'hFF, 8'h00, "ack reads zero");
    bus(1'b1, 8'h40, 8'h5A);
    rd(8'h40, 8'hFF, 8'h00, "unmapped");
    for (int i = 0; i < NUM_CH; i++) begin
      rd(OFF_SPS[i], 8'hFF, RST_SLOT_PORT, "slot reset");
      rd(OFF_DATA[i], 8'hFF, RST_DATA, "data reset");
      bus(1'b1, OFF_DATA[i], 8'hC3 ^ i[7:0]);
      rd(OFF_DATA[i], 8'hFF, 8'hC3 ^ i[7:0], "data rw");
    end
    bus(1'b1, OFF_SLOT_PORT_SELECT_A0, 8'h1F);
    bus(1'b1, OFF_SLOT_PORT_SELECT_A1, 8'h25);
    bus(1'b1, OFF_PAIR_CONTROL_A, 8'h03);
    frames(2);
    rd(OFF_SLOT_ACCESS_DATA_A0, 8'hFF, 8'h5F, "a0 own slot");
    rd(OFF_SLOT_ACCESS_DATA_A1, 8'hFF, 8'hA5, "a1 own slot");
    bus(1'b1, OFF_PAIR_CONTROL_A, 8'h13);
    frames(2);
    rd(OFF_SLOT_ACCESS_DATA_A0, 8'hFF, 8'hA5, "a0 swapped");
    rd(OFF_SLOT_ACCESS_DATA_A1, 8'hFF, 8'h5F, "a1 swapped");
    bus(1'b1, OFF_PAIR_CONTROL_A, 8'h10);
    bus(1'b1, OFF_SLOT_ACCESS_DATA_A0, 8'h3C);
    frames(1);
    rd(OFF_SLOT_ACCESS_DATA_A0, 8'hFF, 8'h3C, "input off holds");
    monitorReverse <= 4'h1;
    bus(1'b1, OFF_PAIR_CONTROL_A, 8'h01);
    bus(1'b1, OFF_SLOT_ACCESS_DATA_A1, 8'h00);
    frames(1);
    rd(OFF_SLOT_ACCESS_DATA_A1, 8'hFF, 8'h5F, "reversed store");
    rd(OFF_SLOT_ACCESS_DATA_A0, 8'hFF, 8'h3C, "reversed keeps");
    monitorReverse <= 4'h0;
    frames(1);
    rd(OFF_SLOT_ACCESS_DATA_A0, 8'hFF, 8'h5F, "plain store");
    bus(1'b1, OFF_SLOT_PORT_SELECT_B0, 8'h27);
    bus(1'b1, OFF_SLOT_ACCESS_DATA_B0, 8'h96);
    wait_for(4, 5000);
    bus(1'b1, OFF_PAIR_CONTROL_B, 8'h14);
    grab(1'b1);
    check("drive downstream", got, 8'h96);
    bus(1'b1, OFF_SLOT_PORT_SELECT_B0, 8'h07);
    grab(1'b0);
    check("drive upstream", got, 8'h96);
    bus(1'b1, OFF_PAIR_CONTROL_B, 8'h00);
    bus(1'b1, OFF_SYNC_TRANSFER_MASK, 8'hEE);
    bus(1'b1, OFF_SYNC_TRANSFER_ACK, 8'h01);
    rd(OFF_SYNC_TRANSFER_STAT, 8'h00, 8'h00, "clear");
    wait_for(1, 5000);
    bus(1'b1, OFF_SYNC_TRANSFER_ACK, 8'h01);
    frames(1);
    rd(OFF_SYNC_TRANSFER_STAT, 8'h10, 8'h00, "acked in time");
    wait_for(1, 5000);
    frames(1);
    rd(OFF_SYNC_TRANSFER_STAT, 8'h11, 8'h11, "missed ack");
    rd(OFF_SYNC_TRANSFER_STAT, 8'h11, 8'h00, "read cleared");
    check("irq after clear", {7'h00, irq}, 8'h00);
    wait_for(1, 5000);
    rd(OFF_SYNC_TRANSFER_STAT, 8'h01, 8'h01, "event bit");
    bus(1'b1, OFF_SYNC_TRANSFER_MASK, 8'hFF);
    frames(2);
    check("irq masked", {7'h00, irq}, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
